// ### design/video_host_general_registers.sv
// Behaviour
// - Read type 0 returns addressed plane byte.
// - Read type 1 returns colour compare result.
// - Writes enable planes by address and mask.
// - Output control written 03C2, read 03CC, reset zero.
// - Bits 7/6 select negative sync polarity.
// - Bit 5 picks upper 64K odd/even page.
// - Bits 3:2 select pixel clock source.
// - Bit 1 gates host memory decode.
// - Bit 0 relocates CRT, status, feature ports.
// - Status 0 bit 7 shows pending retrace interrupt.
// - Status 0 bit 4 shows switch sense.
// - Status 1 bits 5:4 show selected palette pair.
// - Status 1 bit 3 shows vertical retrace.
// - Status 1 bit 0 shows inverted display active.
// - Feature control read fixed, written relocatable.
// - Subsystem enable bit gates all decoding except its own port.
// - Subsystem enable port ignores sleep bit.
// - Sequencer index steers data port accesses.
// - Six register groups decoded; CRT and status 1 ports move with bit 0.
// - Sequencer starts at a character clock with both reset bits; async bit stops it at once.
module video_host_general_registers
  import video_host_pkg::*;
#(
  parameter int PLANES = 4
) (
  input wire logic ref_clk, // 20 MHz clock
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic [15:0] io_addr, // Host I/O port address
  input wire logic io_wr, // Host I/O write strobe
  input wire logic io_rd, // Host I/O read strobe
  input wire logic [7:0] io_wdata, // Host I/O write data
  output logic [7:0] io_rdata, // Host I/O read data
  output logic io_rvalid, // Read answer valid
  input wire logic video_sleep, // Option-select sleep bit
  output video_host_pkg::group_e io_group, // Group of a forwarded access
  output logic io_group_wr, // Forwarded write pulse
  output logic io_group_rd, // Forwarded read pulse
  output logic [1:0] io_group_port, // Low two bits of the host I/O port address
  output logic [7:0] io_group_wdata, // Forwarded write data
  output logic [2:0] seq_index, // Sequencer index
  input wire logic [7:0] ext_rdata, // Read data of forwarded groups
  input wire logic host_mem_wr, // Host memory write strobe
  input wire logic host_mem_rd, // Host memory read strobe
  input wire logic [16:0] host_mem_addr, // Offset inside memory window
  input wire logic [7:0] host_mem_wdata, // Host memory write data
  output logic [7:0] host_mem_rdata, // Host memory read data
  output logic host_mem_ack, // Host memory access done
  output logic ram_wr, // Plane write pulse
  output logic ram_rd, // Plane read pulse
  output logic [3:0] ram_planes, // Planes enabled for the write
  output logic [15:0] ram_addr, // Address inside each plane
  output logic [7:0] ram_wdata, // Byte written to the planes
  input wire logic [PLANES*8-1:0] ram_rdata, // Plane bytes, in the same cycle as ram_rd
  input wire logic read_type, // Read type from graphics mode
  input wire logic [1:0] read_map, // Read plane selection
  input wire logic [3:0] compare_value, // Colour compare value
  input wire logic [3:0] compare_care, // Colour compare plane enables
  input wire logic [3:0] map_mask, // Plane write mask
  input wire logic chain4, // Chain-four mode
  input wire logic odd_even, // Odd/even addressing mode
  input wire logic vint_pending, // Vertical retrace interrupt pending
  input wire logic switch_sense, // Monitor-type switch sense level
  input wire logic [1:0] plane_out_sel, // Diagnostic palette pair select
  input wire logic [7:0] palette_out, // Palette outputs P7..P0
  input wire logic vretrace, // Vertical retrace interval
  input wire logic display_active, // Display active, high when showing video
  input wire logic char_clk_en, // Character clock enable pulse
  output logic vsync_neg, // Negative vertical sync polarity
  output logic hsync_neg, // Negative horizontal sync polarity
  output logic page_high, // Upper odd/even page
  output logic [1:0] clk_sel, // Pixel clock source select
  output logic mem_decode_en, // Host memory decode on
  output logic io_color, // Colour port layout selected
  output logic seq_run // Sequencer running
);

  typedef struct packed {
    logic [7:0] outctl;
    logic [7:0] feat;
    logic subsys;
    logic [2:0] idx;
    logic [1:0] seq_rst;
    logic seq_run;
    group_e grp;
    logic grp_wr;
    logic grp_rd;
    logic [1:0] grp_port;
    logic [7:0] grp_wdata;
    logic rd_pend;
    logic rd_own;
    logic [7:0] own_data;
    logic [7:0] io_rdata;
    logic io_rvalid;
    mem_phase_e mphase;
    logic [1:0] rd_plane;
    logic ram_wr;
    logic ram_rd;
    logic [3:0] ram_planes;
    logic [15:0] ram_addr;
    logic [7:0] ram_wdata;
    logic [7:0] mem_rdata;
    logic mem_ack;
  } state_s;

  state_s st;
  state_s next_st;
  logic [3:0] sel_planes;
  logic [1:0] sel_read_plane;
  logic [15:0] sel_addr;
  logic [7:0] cmp_match;
  logic io_on;
  logic [15:0] reloc_port;
  logic [15:0] crt_index_port;
  logic [15:0] crt_data_port;
  logic [7:0] status0;
  logic [7:0] status1;
  logic [1:0] diag_pair;

  plane_select u_plane_select (
    .host_addr(host_mem_addr),
    .chain4(chain4),
    .odd_even(odd_even),
    .page_high(st.outctl[OC_PAGE_HIGH]),
    .map_mask(map_mask),
    .read_map(read_map),
    .write_planes(sel_planes),
    .read_plane(sel_read_plane),
    .plane_addr(sel_addr)
  );

  color_compare #(
    .PLANES(PLANES)
  ) u_color_compare (
    .plane_data(ram_rdata),
    .compare_value(compare_value[PLANES-1:0]),
    .compare_care(compare_care[PLANES-1:0]),
    .match(cmp_match)
  );

  always_comb
  begin
    io_on = st.subsys && !video_sleep;
    reloc_port = st.outctl[OC_IO_COLOR] ? PORT_RELOC_COLOR : PORT_RELOC_MONO;
    crt_index_port = st.outctl[OC_IO_COLOR] ? PORT_CRT_INDEX_COLOR : PORT_CRT_INDEX_MONO;
    crt_data_port = st.outctl[OC_IO_COLOR] ? PORT_CRT_DATA_COLOR : PORT_CRT_DATA_MONO;
    case (plane_out_sel)
      2'h0: diag_pair = {palette_out[2], palette_out[0]};
      2'h1: diag_pair = {palette_out[5], palette_out[4]};
      2'h2: diag_pair = {palette_out[3], palette_out[1]};
      2'h3: diag_pair = {palette_out[7], palette_out[6]};
      default: diag_pair = 2'h0;
    endcase
    status0 = 8'h00;
    status0[ST0_VINT] = vint_pending;
    status0[ST0_SENSE] = switch_sense;
    status1 = 8'h00;
    status1[ST1_DIAG_HI] = diag_pair[1];
    status1[ST1_DIAG_LO] = diag_pair[0];
    status1[ST1_VRETRACE] = vretrace;
    status1[ST1_NOT_ACTIVE] = !display_active;
  end

  always_comb
  begin
    next_st = st;
    next_st.grp_wr = 1'b0;
    next_st.grp_rd = 1'b0;
    next_st.io_rvalid = 1'b0;
    next_st.ram_wr = 1'b0;
    next_st.ram_rd = 1'b0;
    next_st.mem_ack = 1'b0;
    next_st.rd_pend = 1'b0;

    // Second stage of an I/O read: own data or the forwarded group's answer.
    if (st.rd_pend)
    begin
      next_st.io_rdata = st.rd_own ? st.own_data : ext_rdata;
      next_st.io_rvalid = 1'b1;
    end

    if (io_wr || io_rd)
    begin
      next_st.grp_port = io_addr[1:0];
      next_st.grp_wdata = io_wdata;
      next_st.own_data = 8'h00;
      next_st.rd_own = 1'b1;
      next_st.rd_pend = io_rd;
      if (io_addr == PORT_SUBSYS)
      begin
        if (io_wr)
        begin
          next_st.subsys = io_wdata[SUBSYS_EN_BIT];
        end
        next_st.own_data = {7'h00, st.subsys};
      end
      else if (!io_on)
      begin
        next_st.rd_pend = 1'b0;
      end
      else if (io_addr == PORT_OUTCTL_WR && io_wr)
      begin
        next_st.outctl = io_wdata & OC_WRITE_MASK;
      end
      else if (io_addr == PORT_STATUS0)
      begin
        next_st.own_data = status0;
      end
      else if (io_addr == PORT_OUTCTL_RD)
      begin
        next_st.own_data = io_rd ? st.outctl : 8'h00;
        next_st.rd_pend = io_rd;
      end
      else if (io_addr == PORT_FEAT_RD)
      begin
        next_st.own_data = st.feat;
        next_st.rd_pend = io_rd;
      end
      else if (io_addr == reloc_port)
      begin
        if (io_wr)
        begin
          next_st.feat = io_wdata & FEAT_WRITE_MASK;
        end
        next_st.own_data = status1;
      end
      else if (io_addr == PORT_SEQ_INDEX)
      begin
        if (io_wr)
        begin
          next_st.idx = io_wdata[2:0];
        end
        next_st.own_data = {5'h00, st.idx};
      end
      else if (io_addr == PORT_SEQ_DATA)
      begin
        if (st.idx == SEQ_IDX_RESET)
        begin
          if (io_wr)
          begin
            next_st.seq_rst = io_wdata[1:0];
          end
          next_st.own_data = {6'h00, st.seq_rst};
        end
        else if (st.idx <= SEQ_IDX_LAST)
        begin
          next_st.grp = grp_seq;
          next_st.grp_wr = io_wr;
          next_st.grp_rd = io_rd;
          next_st.rd_own = 1'b0;
        end
      end
      else if (io_addr == PORT_ATTR_INDEX || io_addr == PORT_ATTR_DATA)
      begin
        next_st.grp = grp_attr;
        next_st.grp_wr = io_wr;
        next_st.grp_rd = io_rd;
        next_st.rd_own = 1'b0;
      end
      else if (io_addr == crt_index_port || io_addr == crt_data_port)
      begin
        next_st.grp = grp_crt;
        next_st.grp_wr = io_wr;
        next_st.grp_rd = io_rd;
        next_st.rd_own = 1'b0;
      end
      else if (io_addr == PORT_GFX_INDEX || io_addr == PORT_GFX_DATA)
      begin
        next_st.grp = grp_gfx;
        next_st.grp_wr = io_wr;
        next_st.grp_rd = io_rd;
        next_st.rd_own = 1'b0;
      end
      else if (io_addr >= PORT_DAC_FIRST && io_addr <= PORT_DAC_LAST)
      begin
        next_st.grp = grp_dac;
        next_st.grp_wr = io_wr;
        next_st.grp_rd = io_rd;
        next_st.rd_own = 1'b0;
      end
      else
      begin
        // Unmapped ports are left to other devices on the bus.
        next_st.rd_pend = 1'b0;
      end
    end

    if (!st.seq_rst[SEQ_RST_ASYNC] || !next_st.seq_rst[SEQ_RST_ASYNC])
    begin
      next_st.seq_run = 1'b0;
    end
    else if (char_clk_en)
    begin
      next_st.seq_run = st.seq_rst[SEQ_RST_SYNC];
    end

    // Host memory path; accesses are dropped while decode is off.
    case (st.mphase)
      mem_idle:
      begin
        if (io_on && st.outctl[OC_MEM_EN])
        begin
          if (host_mem_wr)
          begin
            next_st.ram_wr = 1'b1;
            next_st.ram_planes = sel_planes;
            next_st.ram_addr = sel_addr;
            next_st.ram_wdata = host_mem_wdata;
            next_st.mem_ack = 1'b1;
          end
          else if (host_mem_rd)
          begin
            next_st.ram_rd = 1'b1;
            next_st.ram_planes = 4'h0;
            next_st.ram_addr = sel_addr;
            next_st.rd_plane = sel_read_plane;
            next_st.mphase = mem_read;
          end
        end
      end
      mem_read:
      begin
        if (read_type)
        begin
          next_st.mem_rdata = cmp_match;
        end
        else
        begin
          next_st.mem_rdata = ram_rdata[8*st.rd_plane +: 8];
        end
        next_st.mem_ack = 1'b1;
        next_st.mphase = mem_idle;
      end
      default:
      begin
        next_st.mphase = mem_idle;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st <= '0;
      st.outctl <= OUTCTL_RESET;
      st.feat <= FEAT_RESET;
      st.subsys <= SUBSYS_RESET;
      st.idx <= SEQ_IDX_RESET_VAL;
      st.seq_rst <= SEQ_RST_RESET;
      st.grp <= grp_none;
      st.mphase <= mem_idle;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Every output is a flop of the state record.
  assign io_rdata = st.io_rdata;
  assign io_rvalid = st.io_rvalid;
  assign io_group = st.grp;
  assign io_group_wr = st.grp_wr;
  assign io_group_rd = st.grp_rd;
  assign io_group_port = st.grp_port;
  assign io_group_wdata = st.grp_wdata;
  assign seq_index = st.idx;
  assign host_mem_rdata = st.mem_rdata;
  assign host_mem_ack = st.mem_ack;
  assign ram_wr = st.ram_wr;
  assign ram_rd = st.ram_rd;
  assign ram_planes = st.ram_planes;
  assign ram_addr = st.ram_addr;
  assign ram_wdata = st.ram_wdata;
  assign vsync_neg = st.outctl[OC_VSYNC_NEG];
  assign hsync_neg = st.outctl[OC_HSYNC_NEG];
  assign page_high = st.outctl[OC_PAGE_HIGH];
  assign clk_sel = st.outctl[OC_CLK_SEL_HI:OC_CLK_SEL_LO];
  assign mem_decode_en = st.outctl[OC_MEM_EN];
  assign io_color = st.outctl[OC_IO_COLOR];
  assign seq_run = st.seq_run;

endmodule

// ### design/video_host_pkg.sv
package video_host_pkg;

  // Host I/O port addresses of the general registers and the register groups.
  localparam logic [15:0] PORT_OUTCTL_WR = 16'h03C2;
  localparam logic [15:0] PORT_OUTCTL_RD = 16'h03CC;
  localparam logic [15:0] PORT_STATUS0 = 16'h03C2;
  localparam logic [15:0] PORT_SUBSYS = 16'h03C3;
  localparam logic [15:0] PORT_FEAT_RD = 16'h03CA;
  localparam logic [15:0] PORT_RELOC_MONO = 16'h03BA;
  localparam logic [15:0] PORT_RELOC_COLOR = 16'h03DA;
  localparam logic [15:0] PORT_ATTR_INDEX = 16'h03C0;
  localparam logic [15:0] PORT_ATTR_DATA = 16'h03C1;
  localparam logic [15:0] PORT_CRT_INDEX_MONO = 16'h03B4;
  localparam logic [15:0] PORT_CRT_DATA_MONO = 16'h03B5;
  localparam logic [15:0] PORT_CRT_INDEX_COLOR = 16'h03D4;
  localparam logic [15:0] PORT_CRT_DATA_COLOR = 16'h03D5;
  localparam logic [15:0] PORT_SEQ_INDEX = 16'h03C4;
  localparam logic [15:0] PORT_SEQ_DATA = 16'h03C5;
  localparam logic [15:0] PORT_GFX_INDEX = 16'h03CE;
  localparam logic [15:0] PORT_GFX_DATA = 16'h03CF;
  localparam logic [15:0] PORT_DAC_FIRST = 16'h03C6;
  localparam logic [15:0] PORT_DAC_LAST = 16'h03C9;

  // Output control field positions.
  localparam int OC_VSYNC_NEG = 7;
  localparam int OC_HSYNC_NEG = 6;
  localparam int OC_PAGE_HIGH = 5;
  localparam int OC_CLK_SEL_HI = 3;
  localparam int OC_CLK_SEL_LO = 2;
  localparam int OC_MEM_EN = 1;
  localparam int OC_IO_COLOR = 0;
  localparam logic [7:0] OC_WRITE_MASK = 8'hEF;

  // Pixel clock select codes: 25.175 MHz for 640 pixels, 28.322 MHz for 720 pixels.
  localparam logic [1:0] CLK_SEL_640 = 2'h0;
  localparam logic [1:0] CLK_SEL_720 = 2'h1;

  // Status field positions.
  localparam int ST0_VINT = 7;
  localparam int ST0_SENSE = 4;
  localparam int ST1_DIAG_HI = 5;
  localparam int ST1_DIAG_LO = 4;
  localparam int ST1_VRETRACE = 3;
  localparam int ST1_NOT_ACTIVE = 0;

  localparam int SUBSYS_EN_BIT = 0;
  localparam logic [7:0] FEAT_WRITE_MASK = 8'hF7;
  localparam int SEQ_RST_ASYNC = 0;
  localparam int SEQ_RST_SYNC = 1;
  localparam logic [2:0] SEQ_IDX_RESET = 3'h0;
  localparam logic [2:0] SEQ_IDX_LAST = 3'h4;

  // Values after reset.
  localparam logic [7:0] OUTCTL_RESET = 8'h00;
  localparam logic SUBSYS_RESET = 1'b1;
  localparam logic [2:0] SEQ_IDX_RESET_VAL = 3'h0;
  localparam logic [7:0] FEAT_RESET = 8'h00;
  localparam logic [1:0] SEQ_RST_RESET = 2'h3;

  // Cycles from an I/O read strobe to its answer.
  localparam int IO_READ_LATENCY = 2;

  typedef enum logic [2:0] {
    grp_none,
    grp_general,
    grp_attr,
    grp_crt,
    grp_seq,
    grp_gfx,
    grp_dac
  } group_e;

  typedef enum logic [1:0] {
    mem_idle,
    mem_read
  } mem_phase_e;

endpackage

// ### design/plane_select.sv
// Decodes which planes a host memory access touches and where inside them.
module plane_select
  import video_host_pkg::*;
(
  input wire logic [16:0] host_addr, // Offset inside the memory window
  input wire logic chain4, // Low two address bits pick the plane
  input wire logic odd_even, // Even addresses to planes 0/2, odd to 1/3
  input wire logic page_high, // Upper 64K page in odd/even modes
  input wire logic [3:0] map_mask, // Plane write mask
  input wire logic [1:0] read_map, // Read plane selection
  output logic [3:0] write_planes, // Planes enabled for a write
  output logic [1:0] read_plane, // Plane returned by a plain read
  output logic [15:0] plane_addr // Address inside each plane
);

  always_comb
  begin
    if (chain4)
    begin
      write_planes = 4'(4'h1 << host_addr[1:0]) & map_mask;
      read_plane = host_addr[1:0];
      plane_addr = host_addr[16:2] == 15'h0000 ? 16'h0000 : {1'b0, host_addr[16:2]};
    end
    else if (odd_even)
    begin
      write_planes = (host_addr[0] ? 4'hA : 4'h5) & map_mask;
      read_plane = {read_map[1], host_addr[0]};
      plane_addr = {page_high, host_addr[15:1]};
    end
    else
    begin
      write_planes = map_mask;
      read_plane = read_map;
      plane_addr = host_addr[15:0];
    end
  end

endmodule

// ### design/color_compare.sv
// Colour comparison over the planes set in compare_care, one result bit per pixel of the byte.
module color_compare #(
  parameter int PLANES = 4
) (
  input wire logic [PLANES*8-1:0] plane_data, // Plane bytes of the current read, plane 0 lowest
  input wire logic [PLANES-1:0] compare_value, // Colour to look for
  input wire logic [PLANES-1:0] compare_care, // Planes that take part
  output logic [7:0] match // One where the pixel matches
);

  always_comb
  begin
    for (int bit_i = 0; bit_i < 8; bit_i++)
    begin
      match[bit_i] = 1'b1;
      for (int p = 0; p < PLANES; p++)
      begin
        if (compare_care[p] && (plane_data[p*8+bit_i] != compare_value[p]))
        begin
          match[bit_i] = 1'b0;
        end
      end
    end
  end

endmodule

// ### sim/video_host_general_registers_monitor.sv
module vhgr_monitor
  import video_host_pkg::*;
(
  input wire logic ref_clk, // Clock
  input wire logic arst_n, // Reset, active low
  input wire logic [15:0] io_addr, // Port address
  input wire logic io_rd, // Port read
  input wire logic [7:0] io_rdata, // Read answer
  input wire logic io_rvalid, // Answer valid
  input wire logic video_sleep, // Sleep level
  input wire logic io_group_rd, // Forwarded read
  input wire logic [1:0] io_group_port, // Forwarded port
  input wire logic [7:0] ext_rdata, // Forwarded data
  input wire logic host_mem_wr, // Memory write
  input wire logic host_mem_rd, // Memory read
  input wire logic [16:0] host_mem_addr, // Memory offset
  input wire logic [7:0] host_mem_wdata, // Memory data
  input wire logic host_mem_ack, // Memory done
  input wire logic ram_wr, // Plane write
  input wire logic ram_rd, // Plane read
  input wire logic [3:0] ram_planes, // Plane enables
  input wire logic [15:0] ram_addr, // Plane address
  input wire logic [7:0] ram_wdata, // Plane byte
  input wire logic [3:0] map_mask, // Write mask
  input wire logic chain4, // Chain-four
  input wire logic vint_pending, // Retrace interrupt
  input wire logic switch_sense, // Sense level
  input wire logic vretrace, // Vertical retrace
  input wire logic display_active, // Display active
  input wire logic io_color, // Colour layout
  input wire logic mem_decode_en // Memory decode on
);
  timeunit 1ns / 100ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  rvalid_cause_a: assert property (
    io_rvalid |-> $past(io_rd, 2)) else $error("answer without read");
  sleep_refuse_a: assert property (
    video_sleep && io_rd && io_addr != PORT_SUBSYS |-> ##2 !io_rvalid)
    else $error("answer while asleep");
  status_zero_a: assert property (
    io_rd && io_addr == PORT_STATUS0 ##2 io_rvalid |->
    io_rdata == {$past(vint_pending, 2), 2'b00, $past(switch_sense, 2), 4'h0})
    else $error("status zero wrong");
  status_one_a: assert property (
    io_rvalid && $past(io_rd, 2) && $past(io_addr, 2) ==
    ($past(io_color, 2) ? PORT_RELOC_COLOR : PORT_RELOC_MONO) |->
    io_rdata == {2'b00, io_rdata[5:4], $past(vretrace, 2), 2'b00, !$past(display_active, 2)})
    else $error("status one wrong");
  group_fwd_a: assert property (
    io_group_rd |-> $past(io_rd) && io_group_port == $past(io_addr[1:0])
    ##1 io_rvalid && io_rdata == $past(ext_rdata)) else $error("forwarded read wrong");
  mem_gate_a: assert property (
    (host_mem_wr || host_mem_rd) && (!mem_decode_en || video_sleep) |=> !ram_wr && !ram_rd)
    else $error("memory access not gated");
  mem_write_a: assert property (
    ram_wr |-> $past(host_mem_wr) && host_mem_ack && ram_wdata == $past(host_mem_wdata))
    else $error("plane write wrong");
  read_ack_a: assert property (
    ram_rd |=> host_mem_ack && !ram_rd) else $error("read ack missing");
  chain_planes_a: assert property (
    ram_wr && $past(chain4) |-> ram_planes == ($past(map_mask) &
    (4'h1 << $past(host_mem_addr[1:0]))) && ram_addr[14:0] == $past(host_mem_addr[16:2]))
    else $error("chain planes wrong");
endmodule

bind video_host_general_registers vhgr_monitor mon (.*);

// ### sim/plane_memory_model.sv
module plane_memory_model
  import video_host_pkg::*;
(
  input wire logic ref_clk, // Clock
  input wire logic ram_wr, // Plane write
  input wire logic ram_rd, // Plane read
  input wire logic [3:0] ram_planes, // Plane enables
  input wire logic [15:0] ram_addr, // Plane address
  input wire logic [7:0] ram_wdata, // Plane byte
  output logic [31:0] ram_rdata, // Plane bytes
  input wire video_host_pkg::group_e io_group, // Forwarded group
  input wire logic io_group_rd, // Forwarded read
  input wire logic [1:0] io_group_port, // Forwarded port
  output logic [7:0] ext_rdata // Forwarded answer
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [4][256];
  logic tog = 1'b0;
  always @(posedge ref_clk)
  begin
    tog <= ~tog;
    for (int p = 0; p < 4; p++)
      if (ram_wr && ram_planes[p])
        mem[p][ram_addr[7:0]] <= ram_wdata;
  end
  // Idle lines toggle so a stale byte is never mistaken for an answer.
  always_comb
  begin
    ram_rdata = {32{tog}};
    ext_rdata = {8{~tog}};
    if (ram_rd)
      ram_rdata = {mem[3][ram_addr[7:0]], mem[2][ram_addr[7:0]],
                   mem[1][ram_addr[7:0]], mem[0][ram_addr[7:0]]};
    if (io_group_rd)
      ext_rdata = {io_group, 3'h0, io_group_port};
  end
endmodule

// ### sim/video_host_general_registers_tb_top.sv
`define CHK(nm, e, a) begin checks_done++; if ((a) !== (e)) begin fail_count++; \
  $display("[ERR] %s expected %h seen %h", nm, e, a); end end
module video_host_general_registers_tb_top;
  import video_host_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, arst_n, io_wr, io_rd, io_rvalid, video_sleep, io_group_wr, io_group_rd;
  logic host_mem_wr, host_mem_rd, host_mem_ack, ram_wr, ram_rd, read_type, chain4;
  logic odd_even, vint_pending, switch_sense, vretrace, display_active, char_clk_en;
  logic vsync_neg, hsync_neg, page_high, mem_decode_en, io_color, seq_run;
  logic [15:0] io_addr, ram_addr;
  logic [16:0] host_mem_addr;
  logic [7:0] io_wdata, io_rdata, io_group_wdata, ext_rdata, host_mem_wdata, host_mem_rdata;
  logic [7:0] ram_wdata, palette_out;
  logic [3:0] ram_planes, compare_value, compare_care, map_mask;
  logic [1:0] io_group_port, read_map, plane_out_sel, clk_sel;
  logic [2:0] seq_index;
  logic [31:0] ram_rdata;
  group_e io_group;
  int fail_count = 0, checks_done = 0;
  video_host_general_registers DUT (.*);
  plane_memory_model model (.*);
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic io_write(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1 {io_addr, io_wdata, io_wr} = {a, d, 1'b1};
    @(posedge ref_clk);
    #1 io_wr = 1'b0;
  endtask
  task automatic io_read(input logic [15:0] a, input logic [7:0] e, input logic ok);
    @(posedge ref_clk);
    #1 {io_addr, io_rd} = {a, 1'b1};
    @(posedge ref_clk);
    #1 io_rd = 1'b0;
    @(posedge ref_clk);
    #1 `CHK("io_rvalid", ok, io_rvalid)
    if (ok) `CHK("io_rdata", e, io_rdata)
  endtask
  task automatic mem_op(input logic w, input logic [16:0] a, input logic [7:0] d, e,
                        input logic ok);
    @(posedge ref_clk);
    #1 {host_mem_addr, host_mem_wdata, host_mem_wr, host_mem_rd} = {a, d, w, !w};
    @(posedge ref_clk);
    #1 {host_mem_wr, host_mem_rd} = 2'b00;
    if (!w) @(posedge ref_clk);
    #1 `CHK("host_mem_ack", ok, host_mem_ack)
    if (ok && !w) `CHK("host_mem_rdata", e, host_mem_rdata)
  endtask
  task automatic tick;
    @(posedge ref_clk);
    #1 char_clk_en = 1'b1;
    @(posedge ref_clk);
    #1 char_clk_en = 1'b0;
  endtask
  task automatic t_reset;
    io_read(PORT_OUTCTL_RD, 8'h00, 1'b1);
    io_read(PORT_FEAT_RD, 8'h00, 1'b1);
    io_read(PORT_SUBSYS, 8'h01, 1'b1);
    io_read(PORT_SEQ_INDEX, 8'h00, 1'b1);
    tick();
    `CHK("seq_run", 1'b1, seq_run)
    $display("reset values done");
  endtask
  task automatic t_outctl;
    io_write(PORT_OUTCTL_WR, 8'hFF);
    io_read(PORT_OUTCTL_RD, 8'hEF, 1'b1);
    `CHK("outctl bits", 7'h7F, {vsync_neg, hsync_neg, page_high, clk_sel, mem_decode_en, io_color})
    io_write(PORT_OUTCTL_WR, 8'h86);
    #1 `CHK("clk_sel", CLK_SEL_720, clk_sel)
    `CHK("outctl 400", 7'h46, {vsync_neg, hsync_neg, page_high, clk_sel, mem_decode_en, io_color})
    io_write(PORT_OUTCTL_WR, 8'h62);
    #1 `CHK("outctl 350", 7'h32, {vsync_neg, hsync_neg, page_high, clk_sel, mem_decode_en, io_color})
    $display("output control done");
  endtask
  task automatic t_status;
    int hi[4] = '{2, 5, 3, 7};
    int lo[4] = '{0, 4, 1, 6};
    {vint_pending, switch_sense, vretrace, display_active, palette_out} = {4'b1010, 8'hA5};
    io_read(PORT_STATUS0, 8'h80, 1'b1);
    {vint_pending, switch_sense} = 2'b01;
    io_read(PORT_STATUS0, 8'h10, 1'b1);
    for (int s = 0; s < 4; s++)
    begin
      plane_out_sel = 2'(s);
      io_read(PORT_RELOC_MONO, {2'b00, palette_out[hi[s]], palette_out[lo[s]], 4'h9}, 1'b1);
    end
    io_read(PORT_RELOC_COLOR, 8'h00, 1'b0);
    io_write(PORT_RELOC_MONO, 8'hF7);
    io_write(PORT_RELOC_COLOR, 8'h00);
    io_read(PORT_FEAT_RD, 8'hF7, 1'b1);
    io_write(PORT_OUTCTL_WR, 8'h63);
    {vretrace, display_active} = 2'b01;
    io_read(PORT_RELOC_COLOR, 8'h20, 1'b1);
    $display("status registers done");
  endtask
  task automatic t_seq;
    io_write(PORT_SEQ_INDEX, 8'hFF);
    io_read(PORT_SEQ_INDEX, 8'h07, 1'b1);
    io_write(PORT_SEQ_INDEX, 8'h00);
    io_write(PORT_SEQ_DATA, 8'h02);
    @(posedge ref_clk);
    #1 `CHK("seq_run async", 1'b0, seq_run)
    io_read(PORT_SEQ_DATA, 8'h02, 1'b1);
    io_write(PORT_SEQ_DATA, 8'h03);
    tick();
    `CHK("seq_run both", 1'b1, seq_run)
    io_write(PORT_SEQ_DATA, 8'h01);
    @(posedge ref_clk);
    #1 `CHK("seq_run wait", 1'b1, seq_run)
    tick();
    `CHK("seq_run sync", 1'b0, seq_run)
    io_write(PORT_SEQ_DATA, 8'h03);
    io_write(PORT_SEQ_INDEX, 8'h02);
    io_read(PORT_SEQ_DATA, {grp_seq, 5'h01}, 1'b1);
    `CHK("seq_index", 3'h2, seq_index)
    io_write(PORT_SEQ_INDEX, 8'h05);
    io_read(PORT_SEQ_DATA, 8'h00, 1'b1);
    io_read(PORT_GFX_DATA, {grp_gfx, 5'h03}, 1'b1);
    io_read(PORT_CRT_INDEX_COLOR, {grp_crt, 5'h00}, 1'b1);
    io_read(PORT_ATTR_DATA, {grp_attr, 5'h01}, 1'b1);
    io_read(PORT_DAC_LAST, {grp_dac, 5'h01}, 1'b1);
    io_write(PORT_GFX_INDEX, 8'h5C);
    `CHK("group write", {1'b1, 8'h5C}, {io_group_wr, io_group_wdata})
    $display("sequencer and groups done");
  endtask
  task automatic t_mem;
    {chain4, odd_even, read_type, read_map, map_mask} = {5'b00000, 4'h1};
    mem_op(1'b1, 17'h00010, 8'h0F, 8'h00, 1'b1);
    map_mask = 4'h4;
    mem_op(1'b1, 17'h00010, 8'h5A, 8'h00, 1'b1);
    read_map = 2'h2;
    mem_op(1'b0, 17'h00010, 8'h00, 8'h5A, 1'b1);
    {read_type, compare_value, compare_care} = {1'b1, 4'h4, 4'h5};
    mem_op(1'b0, 17'h00010, 8'h00, 8'h50, 1'b1);
    {chain4, read_type, map_mask} = {2'b10, 4'hF};
    mem_op(1'b1, 17'h00042, 8'h33, 8'h00, 1'b1);
    chain4 = 1'b0;
    mem_op(1'b0, 17'h00010, 8'h00, 8'h33, 1'b1);
    {odd_even, read_map} = 3'b100;
    mem_op(1'b1, 17'h00021, 8'hC3, 8'h00, 1'b1);
    `CHK("ram_addr page", 16'h8010, ram_addr)
    mem_op(1'b0, 17'h00021, 8'h00, 8'hC3, 1'b1);
    io_write(PORT_OUTCTL_WR, 8'h61);
    mem_op(1'b1, 17'h00021, 8'h11, 8'h00, 1'b0);
    io_write(PORT_OUTCTL_WR, 8'h63);
    io_write(PORT_SUBSYS, 8'h00);
    io_read(PORT_OUTCTL_RD, 8'h00, 1'b0);
    mem_op(1'b1, 17'h00021, 8'h11, 8'h00, 1'b0);
    video_sleep = 1'b1;
    io_write(PORT_SUBSYS, 8'hFF);
    io_read(PORT_SUBSYS, 8'h01, 1'b1);
    io_read(PORT_OUTCTL_RD, 8'h00, 1'b0);
    mem_op(1'b1, 17'h00021, 8'h11, 8'h00, 1'b0);
    video_sleep = 1'b0;
    io_read(PORT_OUTCTL_RD, 8'h63, 1'b1);
    $display("memory path done");
  endtask
  initial
  begin
    {arst_n, io_wr, io_rd, video_sleep, host_mem_wr, host_mem_rd, char_clk_en} = 7'h00;
    {io_addr, io_wdata, host_mem_addr, host_mem_wdata} = 49'h0;
    {read_type, read_map, compare_value, compare_care, map_mask, chain4, odd_even} = 15'h0;
    {vint_pending, switch_sense, plane_out_sel, palette_out, vretrace, display_active} = 14'h0;
    repeat (3) @(posedge ref_clk);
    #1 arst_n = 1'b1;
    t_reset();
    t_outctl();
    t_status();
    t_seq();
    t_mem();
    final_report();
  end
  // A hang counts as a mismatch and still reaches the verdict.
  initial
  begin
    #2000000;
    fail_count++;
    final_report();
  end
endmodule
